// file: hw/oosc_pkg.sv
// Constants shared by the on/off switch control core.
// Assumes a 200 MHz system clock; analog comparators arrive as logic levels.
package oosc_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int OSC_HZ = 132_000;
    localparam int JIT_PP_HZ = 8_000;
    localparam int JIT_RATE_HZ = 1_000;
    localparam int CYC_NOM = CLK_HZ / OSC_HZ;
    localparam int CYC_MIN = CLK_HZ / (OSC_HZ + JIT_PP_HZ / 2);
    localparam int CYC_MAX = CLK_HZ / (OSC_HZ - JIT_PP_HZ / 2);
    localparam int JIT_SPAN = CYC_MAX - CYC_MIN;
    localparam int JIT_STEP_CYC = CLK_HZ / (JIT_RATE_HZ * 2 * JIT_SPAN);
    localparam int DUTY_PCT = 65;
    localparam int BLANK_NS = 200;
    localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MIN_ON_NS = 400;
    localparam int MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int FAULT_MS = 64;
    localparam int RESTART_MS = 2500;
    localparam int FAULT_OSC = FAULT_MS * (OSC_HZ / 1000);
    localparam int RESTART_OSC = RESTART_MS * (OSC_HZ / 1000);
    localparam int WIN_LEN = 16;
    localparam int HEAVY_CNT = 8;
    localparam int LIGHT_CNT = 3;
    localparam logic [1:0] LIM_LOW = 2'h0;
    localparam logic [1:0] LIM_MID = 2'h1;
    localparam logic [1:0] LIM_HIGH = 2'h2;
    typedef enum logic [1:0] {OOSC_RUN, OOSC_OFF, OOSC_LATCH} oosc_mode_e;
endpackage

// file: hw/oosc_sync.sv
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; no word coherence is given.
`timescale 1ns/1ps
`default_nettype none
module oosc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: hw/oosc_core.sv
// On/off switch control core: jittered oscillator, cycle enable, current-limit
// stepping, protection gating and auto-restart.
// Assumes comparator levels from the analog front end, asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R01) Cycle oscillator averages 132 kHz.
// (R02) Period swept by 8 kHz peak-to-peak triangle at 1 kHz.
// (R03) Oscillator yields cycle-start pulse and max-duty window.
// (R04) Enable sampled at cycle start; high turns switch on for that cycle.
// (R05) Enable changes after sampling ignored; started cycle runs to its end.
// (R06) Enable input is low while pin current exceeds threshold.
// (R07) External feedback holds enable high below reference, low above.
// (R08) Limit machine counts enabled cycles in a window to infer load.
// (R09) Heavy load high limit, medium reduced, very light further reduced.
// (R10) Supply undervoltage inhibits switching until node reaches upper level.
// (R11) Over-temperature flag disables switching until hysteresis clears.
// (R12) Current above limit ends pulse for the rest of cycle.
// (R13) Current comparator masked for a blanking time after turn-on.
// (R14) Fault counter cleared by enable low; 64 ms without low disables 2.5 s.
// (R15) Auto-restart alternates on and off while fault persists.
// (R16) Line undervoltage freezes restart counter during off period.
// (R17) With extension active, pulse stays on until current limit.
// (R18) Extension suppressed until output first reaches regulation.
// (R19) Switching starts only when line-sense current exceeds 25 uA.
// (R20) Supply node held low while line undervoltage at power-up.
// (R21) Missing line resistor disables undervoltage function.
// (R22) Cycle clock runs always; switch on at start, off at limit or duty end.
// (R23) Supply overcurrent latches off until supply low or line current low.
// (R24) Conduction under 400 ns lowers switching frequency.
// (R25) Three limit levels; window counts of enabled cycles set level.
// (R26) Asynchronous comparator inputs pass a two-stage synchroniser.
module oosc_core
    import oosc_pkg::*;
#(
    parameter int FAULT_CYCLES = FAULT_OSC,
    parameter int RESTART_CYCLES = RESTART_OSC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable_in,
    input wire logic line_uv,
    input wire logic line_open,
    input wire logic line_reset,
    input wire logic supply_low,
    input wire logic supply_ok,
    input wire logic over_temp,
    input wire logic shutdown_current_threshold,
    input wire logic cur_over,
    output logic switch_on,
    output logic [1:0] limit_sel,
    output logic hold_supply_low,
    output logic cycle_start,
    output logic max_duty_signal,
    output logic restart_off
);
    import oosc_pkg::*;

    logic rs1_r, rs2_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    wire rst_n = rs2_r;

    logic [8:0] s;
    oosc_sync #(.W(9)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({enable_in, line_uv, line_open, line_reset, supply_low, supply_ok,
            over_temp, shutdown_current_threshold, cur_over}), // see (R26)
        .q(s)
    );
    wire en_s = s[8]; // see (R06)
    wire uv_s = s[7] && !s[6]; // see (R21)
    wire lrst_s = s[5];
    wire slow_s = s[4];
    wire sok_s = s[3];
    wire ot_s = s[2];
    wire sd_s = s[1];
    wire cur_s = s[0];

    function automatic logic [15:0] duty_of(input logic [15:0] per);
        duty_of = 16'((32'(per) * DUTY_PCT) / 100);
    endfunction

    // Switch state is read by the oscillator and mode by the switch pulse, so they are declared first
    logic on_r, on_nxt, ext_ok_r, ext_ok_nxt;
    logic [15:0] on_cnt_r, on_cnt_nxt;
    oosc_mode_e mode_r, mode_nxt;

    // Oscillator and jitter
    logic [15:0] cnt_r, cnt_nxt, per_r, per_nxt;
    logic [15:0] jdiv_r, jdiv_nxt;
    logic jdir_r, jdir_nxt, stretch_r, stretch_nxt;
    logic start_w;
    always_comb begin
        cnt_nxt = cnt_r + 16'h0001;
        per_nxt = per_r;
        jdiv_nxt = jdiv_r + 16'h0001;
        jdir_nxt = jdir_r;
        stretch_nxt = stretch_r;
        start_w = 1'b0;
        if (jdiv_r >= 16'(JIT_STEP_CYC - 1)) begin // see (R02)
            jdiv_nxt = '0;
            if (jdir_r) begin
                if (per_r >= 16'(CYC_MAX)) jdir_nxt = 1'b0;
                else per_nxt = per_r + 16'h0001;
            end else begin
                if (per_r <= 16'(CYC_MIN)) jdir_nxt = 1'b1;
                else per_nxt = per_r - 16'h0001;
            end
        end
        // Short pulses double the period so peak current stays bounded
        if (cnt_r >= (stretch_r ? {per_r[14:0], 1'b0} : per_r) - 16'h0001) begin // see (R24)
            cnt_nxt = '0;
            start_w = 1'b1; // see (R01) see (R22)
            stretch_nxt = 1'b0;
        end
        if (on_r && !on_nxt && on_cnt_r < 16'(MIN_ON_CYC)) stretch_nxt = 1'b1; // see (R24)
    end

    // Switch pulse
    logic duty_w;
    assign duty_w = cnt_r < duty_of(per_r); // see (R03)
    logic allow_w;
    always_comb begin
        on_nxt = on_r;
        on_cnt_nxt = on_r ? on_cnt_r + 16'h0001 : '0;
        ext_ok_nxt = ext_ok_r;
        // Only a real cycle-start sample counts; the synchroniser resets low
        if (start_w && !en_s) ext_ok_nxt = 1'b1; // see (R18)
        if (start_w) begin
            on_nxt = en_s && allow_w; // see (R04) see (R05)
            on_cnt_nxt = '0;
        end else if (on_r) begin
            if (cur_s && on_cnt_r >= 16'(BLANK_CYC)) on_nxt = 1'b0; // see (R12) see (R13)
            else if (!duty_w && !ext_ok_r) on_nxt = 1'b0; // see (R22)
            // Extension keeps conducting past duty until limit, see (R17)
        end
        // No pulse in the cycle that enters the off or latched state
        if (!allow_w || mode_nxt != OOSC_RUN) on_nxt = 1'b0;
    end

    // Current-limit selection over a window of cycles
    logic [4:0] win_r, win_nxt, hits_r, hits_nxt;
    logic [1:0] lim_r, lim_nxt;
    always_comb begin
        win_nxt = win_r;
        hits_nxt = hits_r;
        lim_nxt = lim_r;
        if (start_w) begin // see (R08)
            hits_nxt = hits_r + {4'h0, en_s};
            win_nxt = win_r + 5'h01;
            if (win_r == 5'(WIN_LEN - 1)) begin // see (R25)
                win_nxt = '0;
                hits_nxt = '0;
                if (hits_r >= 5'(HEAVY_CNT)) lim_nxt = LIM_HIGH; // see (R09)
                else if (hits_r >= 5'(LIGHT_CNT)) lim_nxt = LIM_MID;
                else lim_nxt = LIM_LOW;
            end
        end
    end

    // Protection and auto-restart
    logic [31:0] fc_r, fc_nxt;
    logic bp_ok_r, bp_ok_nxt, ot_r, ot_nxt, up_r, up_nxt;
    always_comb begin
        mode_nxt = mode_r;
        fc_nxt = fc_r;
        bp_ok_nxt = bp_ok_r;
        ot_nxt = ot_s; // see (R11)
        up_nxt = up_r;
        if (slow_s) bp_ok_nxt = 1'b0; // see (R10)
        else if (sok_s) bp_ok_nxt = 1'b1;
        if (start_w && !uv_s) up_nxt = 1'b1; // see (R19)
        unique case (mode_r)
            OOSC_RUN: begin
                if (start_w) begin
                    if (!en_s) fc_nxt = '0; // see (R14)
                    else if (fc_r >= 32'(FAULT_CYCLES - 1)) begin
                        fc_nxt = '0;
                        mode_nxt = OOSC_OFF;
                    end else fc_nxt = fc_r + 32'h0000_0001;
                end
            end
            OOSC_OFF: begin
                if (start_w && !uv_s) begin // see (R16)
                    if (fc_r >= 32'(RESTART_CYCLES - 1)) begin
                        fc_nxt = '0;
                        mode_nxt = OOSC_RUN; // see (R15)
                    end else fc_nxt = fc_r + 32'h0000_0001;
                end
            end
            OOSC_LATCH: begin
                if (slow_s || lrst_s) begin // see (R23)
                    mode_nxt = OOSC_RUN;
                    fc_nxt = '0;
                end
            end
        endcase
        if (sd_s) mode_nxt = OOSC_LATCH; // see (R23)
    end
    assign allow_w = bp_ok_r && !ot_r && up_r && !uv_s && mode_r == OOSC_RUN; // see (R19)

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            per_r <= 16'(CYC_NOM);
            jdiv_r <= '0;
            jdir_r <= 1'b0;
            stretch_r <= 1'b0;
            on_r <= 1'b0;
            on_cnt_r <= '0;
            ext_ok_r <= 1'b0;
            win_r <= '0;
            hits_r <= '0;
            lim_r <= LIM_HIGH;
            mode_r <= OOSC_RUN;
            fc_r <= '0;
            bp_ok_r <= 1'b0;
            ot_r <= 1'b0;
            up_r <= 1'b0;
            switch_on <= 1'b0;
            limit_sel <= LIM_HIGH;
            hold_supply_low <= 1'b0;
            cycle_start <= 1'b0;
            max_duty_signal <= 1'b0;
            restart_off <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            jdiv_r <= jdiv_nxt;
            jdir_r <= jdir_nxt;
            stretch_r <= stretch_nxt;
            on_r <= on_nxt;
            on_cnt_r <= on_cnt_nxt;
            ext_ok_r <= ext_ok_nxt;
            win_r <= win_nxt;
            hits_r <= hits_nxt;
            lim_r <= lim_nxt;
            mode_r <= mode_nxt;
            fc_r <= fc_nxt;
            bp_ok_r <= bp_ok_nxt;
            ot_r <= ot_nxt;
            up_r <= up_nxt;
            switch_on <= on_nxt;
            limit_sel <= lim_nxt;
            hold_supply_low <= !up_nxt && uv_s; // see (R20)
            cycle_start <= start_w;
            max_duty_signal <= cnt_nxt < duty_of(per_nxt); // see (R03)
            restart_off <= mode_nxt == OOSC_OFF;
        end
    end
endmodule
`default_nettype wire

// file: tb/oosc_stage_model.sv
// Far side: power stage current ramp and opto feedback on the output level.
// Assumes the bench sets the ramp length in clocks and the load drain.
`timescale 1ns/1ps
`default_nettype none
module oosc_stage_model (
    input wire logic clk,
    input wire logic switch_on,
    input wire logic [11:0] ramp,
    input wire logic [3:0] load,
    output logic cur_over,
    output logic enable_in
);
    int on_t = 0;
    int vout = 0;
    int div = 0;
    // Each finished pulse lifts the output; the load drains it slowly
    always @(posedge clk) begin
        on_t <= switch_on ? on_t + 1 : 0;
        if (on_t != 0 && !switch_on) vout <= vout + 32;
        else if (div == 255) vout <= (vout > load) ? vout - load : 0;
        div <= (div + 1) % 256;
    end
    assign cur_over = switch_on && on_t >= ramp;
    assign enable_in = vout < 64;
endmodule
`default_nettype wire

// file: tb/oosc_core_checker.sv
// Assertions on the switch control core ports.
// Assumes binding into oosc_core; inputs settle two clocks after a change.
`timescale 1ns/1ps
`default_nettype none
module oosc_core_checker
    import oosc_pkg::*;
#(
    parameter int FAULT_CYCLES = 20,
    parameter int RESTART_CYCLES = 30
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cycle_start,
    input wire logic switch_on,
    input wire logic max_duty_signal,
    input wire logic cur_over,
    input wire logic supply_low,
    input wire logic supply_ok,
    input wire logic over_temp,
    input wire logic shutdown_current_threshold,
    input wire logic restart_off,
    input wire logic line_uv,
    input wire logic line_open,
    input wire logic [1:0] limit_sel
);
    logic [12:0] gap_r, gap_nxt, on_r, on_nxt;
    logic seen_r, seen_nxt;
    always_comb begin
        gap_nxt = cycle_start ? 13'h0000 : gap_r + 13'h0001;
        on_nxt = switch_on ? on_r + 13'h0001 : 13'h0000;
        seen_nxt = seen_r | cycle_start;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_r <= 13'h0000;
            on_r <= 13'h0000;
            seen_r <= 1'h0;
        end else begin
            gap_r <= gap_nxt;
            on_r <= on_nxt;
            seen_r <= seen_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Margin of one extra clock covers a latch stage behind the synchroniser
    sequence s_uvlo; supply_low ##1 (!supply_ok) [*5]; endsequence
    sequence s_cut; $rose(cur_over) && switch_on && on_r > 13'h0032; endsequence
    a_start_single: assert property (cycle_start |=> !cycle_start)
        else $error("start pulse too long");
    a_period_min: assert property (cycle_start && seen_r |-> gap_r >= CYC_MIN - 1)
        else $error("cycle period too short");
    a_clock_runs: assert property (gap_r <= 2 * CYC_MAX + 4)
        else $error("cycle clock stalled");
    a_on_at_start: assert property ($rose(switch_on) |-> cycle_start && max_duty_signal)
        else $error("switch rose off cycle start");
    a_blank_hold: assert property ($fell(switch_on) |-> on_r >= BLANK_CYC)
        else $error("pulse ended inside blanking");
    a_limit_cut: assert property (s_cut |-> ##[1:4] !switch_on)
        else $error("current limit ignored");
    a_uvlo_gate: assert property (s_uvlo |-> !$rose(switch_on))
        else $error("switching under supply lockout");
    a_hot_gate: assert property (over_temp [*5] |-> !$rose(switch_on))
        else $error("switching while hot");
    a_latch_gate: assert property (shutdown_current_threshold [*5] |-> !$rose(switch_on))
        else $error("switching during shutdown");
    a_restart_quiet: assert property (restart_off [*2] |-> !$rose(switch_on))
        else $error("switching in restart off time");
    a_uv_freeze: assert property ((restart_off && line_uv && !line_open) [*6] |=> restart_off)
        else $error("restart ended under line low");
    a_limit_level: assert property (limit_sel <= LIM_HIGH)
        else $error("limit level out of range");
endmodule
bind oosc_core oosc_core_checker #(.FAULT_CYCLES(FAULT_CYCLES),
    .RESTART_CYCLES(RESTART_CYCLES)) u_chk (.*);
`default_nettype wire

// file: tb/on_off_switch_controller_test.sv
// Bench for the switch core: power-up, light load, pulse ends, protections, restart.
// Assumes the stage model as far side and shortened fault and restart counts.
`timescale 1ns/1ps
`default_nettype none
module on_off_switch_controller_test;
    import oosc_pkg::*;
    localparam int FAULT_CYC = 16;
    localparam int RESTART_CYC = 6;
    logic clk = 1'h0, rstn = 1'h0, line_uv = 1'h1, line_open = 1'h0, line_reset = 1'h0;
    logic supply_low = 1'h0, supply_ok = 1'h1, over_temp = 1'h0;
    logic shutdown_current_threshold = 1'h0;
    logic [11:0] ramp = 12'h04B0;
    logic [3:0] load = 4'hF;
    logic switch_on, hold_supply_low, cycle_start, max_duty_signal, restart_off;
    logic cur_over, enable_in;
    logic [1:0] limit_sel;
    int fails = 0, samples_checked = 0, ticks = 0, n, w, r;
    oosc_core #(.FAULT_CYCLES(FAULT_CYC), .RESTART_CYCLES(RESTART_CYC)) uut (.*);
    oosc_stage_model stage (.*);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task next_start;
        int k;
        k = 0;
        @(posedge clk);
        while (cycle_start !== 1'h1 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        #1;
    endtask
    task starts(input int cnt);
        r = 0;
        repeat (cnt) begin
            next_start;
            if (switch_on === 1'h1) r++;
        end
    endtask
    // Skipped cycles are passed over so the width belongs to a real pulse
    task width;
        int k;
        k = 0;
        do next_start; while (switch_on !== 1'h1 && k++ < 8);
        w = 1;
        while (switch_on === 1'h1 && w < 3000) begin
            @(posedge clk);
            w++;
        end
    endtask
    task t_power_up;
        next_start;
        check({hold_supply_low, switch_on}, 2'h2);
        line_uv = 1'h0;
        width;
        check(w >= CYC_MIN * DUTY_PCT / 100 - 2 && w <= CYC_MAX * DUTY_PCT / 100 + 4, 1);
    endtask
    task t_light;
        // Medium load first: about a third of the cycles are enabled
        load = 4'h2;
        n = 0;
        while (limit_sel !== LIM_MID && n < 40) begin
            next_start;
            n++;
        end
        check(limit_sel, LIM_MID);
        load = 4'h0;
        n = 0;
        while (limit_sel !== LIM_LOW && n < 40) begin
            next_start;
            n++;
        end
        check(switch_on, 1'h0);
        check(limit_sel, LIM_LOW);
        check(restart_off, 1'h0);
    endtask
    task t_pulses;
        int rp [3] = '{1200, 100, 10};
        load = 4'hF;
        foreach (rp[i]) begin
            ramp = rp[i][11:0];
            width;
            n = (rp[i] > BLANK_CYC) ? rp[i] : BLANK_CYC;
            check(w >= n && w <= n + 6, 1);
        end
    endtask
    task t_protect;
        ramp = 12'h0064;
        for (int i = 0; i < 3; i++) begin
            load = 4'hF;
            // Gate after the pulse has ended so no cut falls inside blanking
            next_start;
            repeat (200) @(posedge clk);
            #1;
            if (i == 0) {supply_low, supply_ok} = 2'h2;
            if (i == 1) over_temp = 1'h1;
            if (i == 2) shutdown_current_threshold = 1'h1;
            starts(2);
            check(r, 0);
            {supply_low, over_temp, shutdown_current_threshold} = 3'h0;
            starts(1);
            if (i != 1) check(r, 0);
            {supply_ok, line_reset} = 2'h3;
            starts(1);
            line_reset = 1'h0;
            // Two pulses lift the output so enable goes low and the fault count clears
            load = 4'h0;
            starts(3);
            check(r > 0, 1);
        end
    endtask
    task t_restart;
        load = 4'hF;
        n = 0;
        while (restart_off !== 1'h1 && n < 40) begin
            next_start;
            n++;
        end
        check(n >= FAULT_CYC - 2 && n <= FAULT_CYC + 4, 1);
        check(limit_sel, LIM_HIGH);
        line_uv = 1'h1;
        repeat (RESTART_CYC + 2) next_start;
        line_uv = 1'h0;
        n = 0;
        while (restart_off === 1'h1 && n < 40) begin
            next_start;
            n++;
        end
        check(n >= RESTART_CYC - 2 && n <= RESTART_CYC + 2, 1);
        starts(2);
        check(r > 0, 1);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    // About 110 oscillator cycles of 1515 clocks; the ceiling leaves room before a hang
    always @(posedge clk) begin
        ticks++;
        if (ticks == 300000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rstn = 1'h1;
        t_power_up;
        t_light;
        t_pulses;
        t_protect;
        t_restart;
        report_and_stop;
    end
endmodule
`default_nettype wire
